/* verilog/abort_err_consts.svh */
// Summary of operation
// RULE1: Boot version word holds major number in upper half, minor in lower half; read only.
// RULE2: Boot fieldbus word flags usable buses with the module availability bit layout.
// RULE3: A detected bus failure enters safe-operational, then applies the selected reaction.
// RULE4: Option -1 zeroes all received process data including the controlword; 0 does nothing.
// RULE5: Option 1 requests the configured fault action.
// RULE6: Option 2 goes straight to switched-on-disabled, power removed, no halt ramp.
// RULE7: Option 3 requests the configured quick-stop action.
// RULE8: Error code register shows the newest error code, read only, mappable to transmit data.
// RULE9: Error code equals the low sixteen bits of the newest error history entry.
// RULE10: Master sets controlword bit 7 to clear an error; device then zeroes the code.
// RULE11: The fault-clear bit clears an active error or warning when the state permits.
// RULE12: Each bus-failure event triggers the reaction once; repeats do not retrigger.
`ifndef ABORT_ERR_CONSTS_SVH
`define ABORT_ERR_CONSTS_SVH
`define OBJ_BOOT_INFO 16'h4042
`define OBJ_ABORT_OPT 16'h6007
`define OBJ_ERR_CODE 16'h603F
`define SUB_COUNT 8'h00
`define SUB_BOOT_VER 8'h01
`define SUB_BOOT_BUS 8'h02
`define SUB_BOOT_HWG 8'h03
`define BOOT_ENTRY_COUNT 8'h03
`define ABORT_OPT_RESET 16'h0001
`define ERR_CODE_RESET 16'h0000
`define CW_FAULT_CLEAR_BIT 7
`define VER_HALF_W 16
`endif

/* verilog/abort_err_pkg.sv */
package abort_err_pkg;
   // Abort reaction codes as the 16-bit signed object value.
   typedef enum logic [15:0] {
      ABORT_ZERO_PDO = 16'hFFFF,
      ABORT_NONE = 16'h0000,
      ABORT_FAULT = 16'h0001,
      ABORT_DISABLE_V = 16'h0002,
      ABORT_QUICK_STOP = 16'h0003
   } abort_opt_t;
   // Bus link supervision state.
   typedef enum logic [1:0] {
      LINK_OK = 2'b00,
      LINK_SAFE_OP = 2'b01
   } link_state_t;
endpackage : abort_err_pkg

/* verilog/boot_info_rom.sv */
`timescale 1ns/100ps
`include "abort_err_consts.svh"
module boot_info_rom #(
   parameter logic [15:0] VER_MAJOR = 16'h0000,
   parameter logic [15:0] VER_MINOR = 16'h0000,
   parameter logic [31:0] BUS_MASK = 32'h0000_0000,
   parameter logic [31:0] HW_GROUP = 32'h0000_0000
) (
   input wire logic clk_i,
   input wire logic [1:0] addr_i,
   output logic [31:0] rdata_o
);
   logic [31:0] table_w [0:3];

   // Constant contents; the version word packs major above minor.
   assign table_w[0] = {24'h00_0000, `BOOT_ENTRY_COUNT};
   assign table_w[1] = {VER_MAJOR, VER_MINOR}; // RULE1
   assign table_w[2] = BUS_MASK; // RULE2
   assign table_w[3] = HW_GROUP;

   // Read data always come out of a register.
   always_ff @(posedge clk_i)
   begin
      rdata_o <= table_w[addr_i];
   end
endmodule : boot_info_rom

/* verilog/bus_abort_and_error_code.sv */
`timescale 1ns/100ps
`include "abort_err_consts.svh"
module bus_abort_and_error_code #(
   parameter logic [15:0] BOOT_VER_MAJOR = 16'h0000,
   parameter logic [15:0] BOOT_VER_MINOR = 16'h0000,
   parameter logic [31:0] BOOT_BUS_MASK = 32'h0000_0000,
   parameter logic [31:0] BOOT_HW_GROUP = 32'h0000_0000
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic obj_req_i,
   input wire logic obj_we_i,
   input wire logic [15:0] obj_index_i,
   input wire logic [7:0] obj_subindex_i,
   input wire logic [31:0] obj_wdata_i,
   output logic obj_ack_o,
   output logic obj_err_o,
   output logic [31:0] obj_rdata_o,
   input wire logic rx_valid_i,
   input wire logic [15:0] rx_controlword_i,
   input wire logic [31:0] rx_data_i,
   output logic [15:0] controlword_o,
   output logic [31:0] rx_data_o,
   output logic [15:0] tx_error_code_o,
   input wire logic bus_failure_i,
   input wire logic err_new_i,
   input wire logic [31:0] err_newest_i,
   input wire logic clear_allowed_i,
   output logic safe_op_o,
   output logic fault_action_o,
   output logic disable_voltage_o,
   output logic quick_stop_o,
   output logic pdo_zeroed_o,
   output logic fault_clear_o
);
   import abort_err_pkg::*;

   logic acc_q;
   logic acc_we_q;
   logic [15:0] acc_idx_q;
   logic [7:0] acc_sub_q;
   logic [31:0] acc_wdata_q;
   logic [31:0] rom_rdata;
   abort_opt_t abort_opt_q;
   logic [15:0] err_code_q;
   link_state_t link_q;
   logic fail_seen_q;
   logic fail_event;
   logic cw_bit_q;
   logic clear_event;

   // Checks that an option write carries one of the five defined codes.
   function automatic logic opt_legal(input logic [15:0] v);
      opt_legal = (v == ABORT_ZERO_PDO) || (v == ABORT_NONE) || (v == ABORT_FAULT)
         || (v == ABORT_DISABLE_V) || (v == ABORT_QUICK_STOP);
   endfunction : opt_legal

   // Boot information words live in a small table with registered read.
   boot_info_rom #(
      .VER_MAJOR(BOOT_VER_MAJOR),
      .VER_MINOR(BOOT_VER_MINOR),
      .BUS_MASK(BOOT_BUS_MASK),
      .HW_GROUP(BOOT_HW_GROUP)
   ) u_rom (
      .clk_i(clk_i),
      .addr_i(obj_subindex_i[1:0]),
      .rdata_o(rom_rdata)
   );

   // First access stage: capture the request while the table is read.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         acc_q <= 1'b0;
         acc_we_q <= 1'b0;
         acc_idx_q <= 16'h0000;
         acc_sub_q <= 8'h00;
         acc_wdata_q <= 32'h0000_0000;
      end
      else
      begin
         acc_q <= obj_req_i;
         acc_we_q <= obj_we_i;
         acc_idx_q <= obj_index_i;
         acc_sub_q <= obj_subindex_i;
         acc_wdata_q <= obj_wdata_i;
      end
   end

   // Second access stage: decode the object and answer; writes to read-only ones are refused.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         obj_ack_o <= 1'b0;
         obj_err_o <= 1'b0;
         obj_rdata_o <= 32'h0000_0000;
      end
      else
      begin
         obj_ack_o <= acc_q;
         obj_err_o <= 1'b0;
         obj_rdata_o <= 32'h0000_0000;
         if (!acc_q)
         begin
            obj_err_o <= 1'b0;
         end
         else if (acc_idx_q == `OBJ_ABORT_OPT && acc_sub_q == `SUB_COUNT)
         begin
            if (acc_we_q)
            begin
               obj_err_o <= !opt_legal(acc_wdata_q[15:0]);
            end
            else
            begin
               obj_rdata_o <= {{16{abort_opt_q[15]}}, abort_opt_q};
            end
         end
         else if (acc_idx_q == `OBJ_ERR_CODE && acc_sub_q == `SUB_COUNT)
         begin
            obj_err_o <= acc_we_q;
            obj_rdata_o <= acc_we_q ? 32'h0000_0000 : {16'h0000, err_code_q}; // RULE8
         end
         else if (acc_idx_q == `OBJ_BOOT_INFO && acc_sub_q <= `SUB_BOOT_HWG)
         begin
            obj_err_o <= acc_we_q;
            obj_rdata_o <= acc_we_q ? 32'h0000_0000 : rom_rdata; // RULE1 RULE2
         end
         else
         begin
            obj_err_o <= 1'b1;
         end
      end
   end

   // Reaction select register, updated by legal option writes only.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         abort_opt_q <= abort_opt_t'(`ABORT_OPT_RESET);
      end
      else if (acc_q && acc_we_q && acc_idx_q == `OBJ_ABORT_OPT && acc_sub_q == `SUB_COUNT
               && opt_legal(acc_wdata_q[15:0]))
      begin
         abort_opt_q <= abort_opt_t'(acc_wdata_q[15:0]);
      end
   end

   // A failure counts once on its rising edge while the link is healthy.
   assign fail_event = bus_failure_i && !fail_seen_q && link_q == LINK_OK; // RULE12

   // A fault clear is a rising edge of controlword bit 7 that the state permits.
   assign clear_event = rx_valid_i && rx_controlword_i[`CW_FAULT_CLEAR_BIT] && !cw_bit_q
      && clear_allowed_i; // RULE10 RULE11

   // Edge history of the failure input and of the fault-clear bit.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         fail_seen_q <= 1'b0;
         cw_bit_q <= 1'b0;
      end
      else
      begin
         fail_seen_q <= bus_failure_i;
         if (rx_valid_i)
         begin
            cw_bit_q <= rx_controlword_i[`CW_FAULT_CLEAR_BIT];
         end
      end
   end

   // Link supervision: failure enters safe-operational, a fault clear with the failure input low leaves it.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         link_q <= LINK_OK;
      end
      else
      begin
         case (link_q)
            LINK_OK:
            begin
               if (fail_event)
               begin
                  link_q <= LINK_SAFE_OP; // RULE3
               end
            end
            LINK_SAFE_OP:
            begin
               if (clear_event && !bus_failure_i)
               begin
                  link_q <= LINK_OK; // RULE11
               end
            end
            default:
            begin
               link_q <= LINK_OK;
            end
         endcase
      end
   end

   // One-cycle reaction requests and the held zeroing of received data.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         safe_op_o <= 1'b0;
         fault_action_o <= 1'b0;
         disable_voltage_o <= 1'b0;
         quick_stop_o <= 1'b0;
         pdo_zeroed_o <= 1'b0;
      end
      else
      begin
         // Safe-operational follows the next link state, so it falls with the accepted clear.
         safe_op_o <= fail_event
            || (link_q == LINK_SAFE_OP && !(clear_event && !bus_failure_i)); // RULE3
         fault_action_o <= fail_event && abort_opt_q == ABORT_FAULT; // RULE5
         disable_voltage_o <= fail_event && abort_opt_q == ABORT_DISABLE_V; // RULE6
         quick_stop_o <= fail_event && abort_opt_q == ABORT_QUICK_STOP; // RULE7
         if (fail_event && abort_opt_q == ABORT_ZERO_PDO)
         begin
            pdo_zeroed_o <= 1'b1; // RULE4
         end
         else if (link_q == LINK_SAFE_OP && clear_event && !bus_failure_i)
         begin
            pdo_zeroed_o <= 1'b0;
         end
      end
   end

   // Received process data pass through, forced to zero while zeroing holds.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         controlword_o <= 16'h0000;
         rx_data_o <= 32'h0000_0000;
      end
      else if (pdo_zeroed_o || (fail_event && abort_opt_q == ABORT_ZERO_PDO))
      begin
         controlword_o <= 16'h0000; // RULE4
         rx_data_o <= 32'h0000_0000; // RULE4
      end
      else if (rx_valid_i)
      begin
         controlword_o <= rx_controlword_i;
         rx_data_o <= rx_data_i;
      end
   end

   // Error code follows the newest history entry; a new error wins over a clear.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         err_code_q <= `ERR_CODE_RESET;
         fault_clear_o <= 1'b0;
      end
      else
      begin
         fault_clear_o <= clear_event; // RULE11
         if (err_new_i)
         begin
            err_code_q <= err_newest_i[15:0]; // RULE9
         end
         else if (clear_event)
         begin
            err_code_q <= `ERR_CODE_RESET; // RULE10
         end
      end
   end

   // Transmit copy of the error code for process-data mapping.
   assign tx_error_code_o = err_code_q; // RULE8

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_fail_rise;
      !bus_failure_i ##1 bus_failure_i && link_q == LINK_OK;
   endsequence

   sequence s_fault_opt;
      abort_opt_q == ABORT_FAULT;
   endsequence

   a_safe_op_entry: assert property (s_fail_rise |=> safe_op_o) // RULE3
      else $error("safe-operational not entered after bus failure");
   a_zero_pdo_hold: assert property (fail_event && abort_opt_q == ABORT_ZERO_PDO
      |=> pdo_zeroed_o && controlword_o == 16'h0000 && rx_data_o == 32'h0000_0000) // RULE4
      else $error("received data not zeroed for option -1");
   a_none_quiet: assert property (fail_event && abort_opt_q == ABORT_NONE
      |=> !fault_action_o && !disable_voltage_o && !quick_stop_o && !pdo_zeroed_o) // RULE4
      else $error("option 0 produced a reaction");
   a_fault_request: assert property ((s_fault_opt and fail_event) |=> fault_action_o) // RULE5
      else $error("fault action missing for option 1");
   a_disable_volt: assert property (disable_voltage_o
      |-> $past(abort_opt_q) == ABORT_DISABLE_V && $past(fail_event)) // RULE6
      else $error("disable voltage request without cause");
   a_quick_stop: assert property (quick_stop_o |-> $past(abort_opt_q) == ABORT_QUICK_STOP) // RULE7
      else $error("quick stop request with wrong option");
   a_err_follow: assert property (err_new_i |=> tx_error_code_o == $past(err_newest_i[15:0])) // RULE9
      else $error("error code does not follow newest entry");
   a_err_clear: assert property (clear_event && !err_new_i
      |=> tx_error_code_o == 16'h0000 && fault_clear_o) // RULE10
      else $error("error code not cleared by fault clear");
   a_no_retrigger: assert property (safe_op_o && bus_failure_i
      |=> !fault_action_o && !disable_voltage_o && !quick_stop_o) // RULE12
      else $error("reaction retriggered during one failure");
   a_err_readonly: assert property (acc_q && acc_we_q && acc_idx_q == `OBJ_ERR_CODE
      |=> obj_ack_o && obj_err_o) // RULE8
      else $error("write to error code not refused");
   a_boot_word: assert property (acc_q && !acc_we_q && acc_idx_q == `OBJ_BOOT_INFO
      && acc_sub_q == `SUB_BOOT_VER |=> obj_rdata_o == {BOOT_VER_MAJOR, BOOT_VER_MINOR}) // RULE1
      else $error("boot version word wrong");
   a_bus_mask: assert property (acc_q && !acc_we_q && acc_idx_q == `OBJ_BOOT_INFO
      && acc_sub_q == `SUB_BOOT_BUS |=> obj_rdata_o == BOOT_BUS_MASK) // RULE2
      else $error("boot fieldbus word wrong");
   a_clear_gate: assert property (fault_clear_o |-> $past(clear_allowed_i)) // RULE11
      else $error("fault clear accepted while not permitted");
endmodule : bus_abort_and_error_code

/* bench/fieldbus_master_model.sv */
`timescale 1ns/100ps
// Master side: object accesses and received process data, driven on falling edges.
module fieldbus_master_model (
   input wire logic clk_i,
   output logic obj_req_o,
   output logic obj_we_o,
   output logic [15:0] obj_index_o,
   output logic [7:0] obj_subindex_o,
   output logic [31:0] obj_wdata_o,
   input wire logic obj_ack_i,
   input wire logic obj_err_i,
   input wire logic [31:0] obj_rdata_i,
   output logic rx_valid_o,
   output logic [15:0] rx_controlword_o,
   output logic [31:0] rx_data_o
);
   // Idle levels from time zero.
   initial
   begin
      obj_req_o = 1'b0;
      obj_we_o = 1'b0;
      obj_index_o = 16'h0000;
      obj_subindex_o = 8'h00;
      obj_wdata_o = 32'h0000_0000;
      rx_valid_o = 1'b0;
      rx_controlword_o = 16'h0000;
      rx_data_o = 32'h0000_0000;
   end
   // One request pulse, then four falling edges to catch the one-cycle answer.
   task automatic obj_xfer(input logic we, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] wd, output logic [31:0] rd, output logic err, output logic ok);
      ok = 1'b0;
      @(negedge clk_i);
      obj_req_o = 1'b1;
      obj_we_o = we;
      obj_index_o = idx;
      obj_subindex_o = sub;
      obj_wdata_o = wd;
      @(negedge clk_i);
      obj_req_o = 1'b0;
      obj_wdata_o = ~wd; // Stale data must not be mistaken for the request.
      for (int n = 0; n < 4; n++)
      begin
         @(negedge clk_i);
         if (!ok && obj_ack_i === 1'b1)
         begin
            ok = 1'b1;
            rd = obj_rdata_i;
            err = obj_err_i;
         end
      end
   endtask : obj_xfer
   // One received frame; bit 7 of the controlword asks for a fault clear.
   task automatic pdo_send(input logic [15:0] cw, input logic [31:0] data);
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_controlword_o = cw;
      rx_data_o = data;
      @(negedge clk_i);
      rx_valid_o = 1'b0;
      rx_data_o = ~data;
   endtask : pdo_send
endmodule : fieldbus_master_model

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   logic clk_i = 1'b0;
   logic reset_i, obj_req_i, obj_we_i, obj_ack_o, obj_err_o, rx_valid_i;
   logic [15:0] obj_index_i, rx_controlword_i, controlword_o, tx_error_code_o;
   logic [7:0] obj_subindex_i;
   logic [31:0] obj_wdata_i, obj_rdata_o, rx_data_i, rx_data_o, err_newest_i;
   logic bus_failure_i, err_new_i, clear_allowed_i, safe_op_o, fault_action_o;
   logic disable_voltage_o, quick_stop_o, pdo_zeroed_o, fault_clear_o;
   int err_count = 0;
   int checks_done = 0;
   logic [15:0] opt [5] = '{16'hFFFF, 16'h0000, 16'h0001, 16'h0002, 16'h0003};
   logic [3:0] react [5] = '{4'b0001, 4'b0000, 4'b1000, 4'b0100, 4'b0010};
   logic [2:0] seen;
   // Clock of 100 ns period.
   always #50 clk_i = ~clk_i;
   // Device under test with a version of 4.2 and an arbitrary bus mask.
   bus_abort_and_error_code #(.BOOT_VER_MAJOR(16'h0004), .BOOT_VER_MINOR(16'h0002),
      .BOOT_BUS_MASK(32'h0000_0005), .BOOT_HW_GROUP(32'h0000_00A5)) u_bus_abort_and_error_code (
      .clk_i(clk_i), .reset_i(reset_i), .obj_req_i(obj_req_i), .obj_we_i(obj_we_i),
      .obj_index_i(obj_index_i), .obj_subindex_i(obj_subindex_i), .obj_wdata_i(obj_wdata_i),
      .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o), .obj_rdata_o(obj_rdata_o),
      .rx_valid_i(rx_valid_i), .rx_controlword_i(rx_controlword_i), .rx_data_i(rx_data_i),
      .controlword_o(controlword_o), .rx_data_o(rx_data_o), .tx_error_code_o(tx_error_code_o),
      .bus_failure_i(bus_failure_i), .err_new_i(err_new_i), .err_newest_i(err_newest_i),
      .clear_allowed_i(clear_allowed_i), .safe_op_o(safe_op_o),
      .fault_action_o(fault_action_o), .disable_voltage_o(disable_voltage_o),
      .quick_stop_o(quick_stop_o), .pdo_zeroed_o(pdo_zeroed_o), .fault_clear_o(fault_clear_o));
   // Master model on the object port and the received data port.
   fieldbus_master_model u_fieldbus_master_model (.clk_i(clk_i), .obj_req_o(obj_req_i),
      .obj_we_o(obj_we_i), .obj_index_o(obj_index_i), .obj_subindex_o(obj_subindex_i),
      .obj_wdata_o(obj_wdata_i), .obj_ack_i(obj_ack_o), .obj_err_i(obj_err_o),
      .obj_rdata_i(obj_rdata_o), .rx_valid_o(rx_valid_i), .rx_controlword_o(rx_controlword_i),
      .rx_data_o(rx_data_i));
   // Verdict and end of run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   // Compares one value and counts it.
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // Object access with expected data and refusal flag; a missing answer ends the run.
   task automatic acc(input logic we, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] wd, input logic [31:0] exp, input logic exp_err);
      logic [31:0] rd;
      logic err;
      logic ok;
      u_fieldbus_master_model.obj_xfer(we, idx, sub, wd, rd, err, ok);
      check("object answer", 32'(ok), 32'h1);
      if (ok !== 1'b1)
         stop_test();
      check("object refusal", 32'(err), 32'(exp_err));
      check("object data", rd, exp);
   endtask : acc
   // Bounded wait for safe-op (0) or fault clear (1).
   task automatic wait_hi(input int which);
      logic hit;
      hit = (which == 0) ? safe_op_o === 1'b1 : fault_clear_o === 1'b1;
      for (int n = 0; n < 6 && !hit; n++)
      begin
         @(negedge clk_i);
         hit = (which == 0) ? safe_op_o === 1'b1 : fault_clear_o === 1'b1;
      end
      check("wait", 32'(hit), 32'h1);
      if (!hit)
         stop_test();
   endtask : wait_hi
   // Main sequence: reset, register map, every abort reaction, error code.
   initial
   begin
      reset_i = 1'b1;
      bus_failure_i = 1'b0;
      err_new_i = 1'b0;
      err_newest_i = 32'h0000_0000;
      clear_allowed_i = 1'b0;
      repeat (6) @(negedge clk_i);
      reset_i = 1'b0;
      acc(1'b0, 16'h6007, 8'h00, 32'h0, 32'h0000_0001, 1'b0);
      acc(1'b0, 16'h4042, 8'h00, 32'h0, 32'h0000_0003, 1'b0);
      acc(1'b0, 16'h4042, 8'h01, 32'h0, 32'h0004_0002, 1'b0);
      acc(1'b0, 16'h4042, 8'h02, 32'h0, 32'h0000_0005, 1'b0);
      acc(1'b1, 16'h4042, 8'h01, 32'h1, 32'h0, 1'b1);
      acc(1'b0, 16'h603F, 8'h00, 32'h0, 32'h0, 1'b0);
      acc(1'b1, 16'h603F, 8'h00, 32'h1, 32'h0, 1'b1);
      acc(1'b0, 16'h6008, 8'h00, 32'h0, 32'h0, 1'b1);
      acc(1'b1, 16'h6007, 8'h00, 32'h4, 32'h0, 1'b1);
      acc(1'b0, 16'h6007, 8'h00, 32'h0, 32'h0000_0001, 1'b0);
      $display("test registers done");
      u_fieldbus_master_model.pdo_send(16'h000F, 32'hDEAD_BEEF);
      repeat (2) @(negedge clk_i);
      check("controlword", 32'(controlword_o), 32'h000F);
      check("rx data", rx_data_o, 32'hDEAD_BEEF);
      for (int i = 0; i < 5; i++)
      begin
         acc(1'b1, 16'h6007, 8'h00, {16'h0, opt[i]}, 32'h0, 1'b0);
         acc(1'b0, 16'h6007, 8'h00, 32'h0, {{16{opt[i][15]}}, opt[i]}, 1'b0);
         bus_failure_i = 1'b1;
         wait_hi(0);
         check("reaction", 32'({fault_action_o, disable_voltage_o, quick_stop_o,
            pdo_zeroed_o}), 32'(react[i]));
         @(negedge clk_i);
         check("pulse end", 32'({fault_action_o, disable_voltage_o, quick_stop_o}), 32'h0);
         bus_failure_i = 1'b0;
         @(negedge clk_i);
         bus_failure_i = 1'b1;
         seen = 3'b000;
         repeat (3)
         begin
            @(negedge clk_i);
            seen = seen | {fault_action_o, disable_voltage_o, quick_stop_o};
         end
         check("retrigger", 32'(seen), 32'h0);
         u_fieldbus_master_model.pdo_send(16'h000F, 32'h1234_5678);
         repeat (2) @(negedge clk_i);
         check("zeroed cw", 32'(controlword_o), (i == 0) ? 32'h0 : 32'h000F);
         check("zeroed data", rx_data_o, (i == 0) ? 32'h0 : 32'h1234_5678);
         bus_failure_i = 1'b0;
         clear_allowed_i = 1'b1;
         u_fieldbus_master_model.pdo_send(16'h0080, 32'h0);
         wait_hi(1);
         check("leave safe op", 32'({safe_op_o, pdo_zeroed_o}), 32'h0);
         clear_allowed_i = 1'b0;
         u_fieldbus_master_model.pdo_send(16'h0000, 32'h0);
      end
      $display("test abort reactions done");
      err_new_i = 1'b1;
      err_newest_i = 32'h1234_8130;
      @(negedge clk_i);
      err_new_i = 1'b0;
      err_newest_i = 32'hEDCB_7ECF;
      @(negedge clk_i);
      check("error code", 32'(tx_error_code_o), 32'h8130);
      acc(1'b0, 16'h603F, 8'h00, 32'h0, 32'h0000_8130, 1'b0);
      u_fieldbus_master_model.pdo_send(16'h0080, 32'h0);
      repeat (3) @(negedge clk_i);
      check("clear refused", 32'(tx_error_code_o), 32'h8130);
      u_fieldbus_master_model.pdo_send(16'h0000, 32'h0);
      clear_allowed_i = 1'b1;
      u_fieldbus_master_model.pdo_send(16'h0080, 32'h0);
      wait_hi(1);
      check("code cleared", 32'(tx_error_code_o), 32'h0);
      acc(1'b0, 16'h603F, 8'h00, 32'h0, 32'h0, 1'b0);
      $display("test error code done");
      stop_test();
   end
endmodule : tb_top
